/* dv/i2c_host_model.sv */
// bus host model: start, stop, byte write and byte read
// assumes a pulled-up data wire resolved outside; scl idles high
`timescale 1ns/10ps
module i2c_host_model (
	output logic      scl,
	output logic      sda_low,
	input wire logic  sda
);
	localparam int Q = 80;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start;
		sda_low = 1'b0; #Q scl = 1'b1; #Q sda_low = 1'b1; #Q scl = 1'b0; #Q;
	endtask : start
	task automatic stop;
		sda_low = 1'b1; #Q scl = 1'b1; #Q sda_low = 1'b0; #Q;
	endtask : stop
	task automatic bitx(input logic b, output logic r);
		sda_low = !b; #Q scl = 1'b1; #Q r = sda; #Q scl = 1'b0; #Q;
	endtask : bitx
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask : wb
	task automatic rb(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(!more, r);
	endtask : rb
endmodule : i2c_host_model

/* dv/thermal_alarm_assertions.sv */
// checker for the thermal alarm block, bound to its ports
// assumes clk_sys runs free and nrst is synchronous active low
`timescale 1ns/10ps
module thermal_alarm_assertions #(
	parameter int TIMEOUT_CYC = 200
) (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        scl_i,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        os_o,
	input wire logic        os_oe,
	input wire logic        conv_en,
	input wire logic        conv_done,
	input wire logic [4:0]  idle_period
);
	logic scl_d;
	int   sq;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// cycles since the last bus clock edge, saturating past the time-out
	always_ff @(posedge clk_sys) begin
		scl_d <= scl_i;
		if (!nrst || scl_i != scl_d)
			sq <= 0;
		else if (sq <= TIMEOUT_CYC)
			sq <= sq + 1;
	end
	sequence s_scl_high;
		scl_i [*2];
	endsequence
	property p_rst_vals;
		$rose(nrst) |-> !sda_oe && !os_oe && conv_en && idle_period == 5'h01;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
	property p_od_low;
		sda_o == 1'b0 && os_o == 1'b0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open drain drives high");
	property p_sda_stable;
		s_scl_high |-> $stable(sda_oe);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("sda moved with scl high");
	property p_sda_cause;
		$changed(sda_oe) |-> sq < 8 || sq >= TIMEOUT_CYC;
	endproperty
	a_sda_cause: assert property (p_sda_cause) else $error("sda moved on idle bus");
	property p_os_cause;
		$changed(os_oe) |-> $past(conv_done, 2) || sq < 12;
	endproperty
	a_os_cause: assert property (p_os_cause) else $error("alarm moved without cause");
	property p_conv_cause;
		$changed(conv_en) |-> sq < 12;
	endproperty
	a_conv_cause: assert property (p_conv_cause) else $error("conv_en moved without write");
	property p_idle_cause;
		$changed(idle_period) |-> sq < 12;
	endproperty
	a_idle_cause: assert property (p_idle_cause) else $error("idle moved without write");
	property p_shut_ignore;
		conv_done && !conv_en && sq > 2 |-> ##2 $stable(os_oe);
	endproperty
	a_shut_ignore: assert property (p_shut_ignore) else $error("conversion used in shutdown");
endmodule : thermal_alarm_assertions
bind thermal_alarm thermal_alarm_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
	.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.os_o(os_o), .os_oe(os_oe), .conv_en(conv_en), .conv_done(conv_done),
	.idle_period(idle_period));

/* dv/thermal_alarm_tb.sv */
// self-checking bench for the thermal alarm block
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/10ps
module thermal_alarm_tb;
	import thermal_alarm_pkg::*;
	localparam logic [10:0] HOT = 11'h290, AT_OVER = 11'h283, COLD = 11'h200, AT_HYST = 11'h25B;
	logic        clk_sys = 1'b0, nrst = 1'b0, conv_done = 1'b0;
	logic [10:0] conv_temp = 11'h000;
	logic        scl, host_low, sda_oe, os_oe, conv_en, ack;
	logic [4:0]  idle_period;
	logic [15:0] rd;
	int          bad_count, checked, cyc, tbl[4] = '{1, 2, 4, 6};
	wire         sda = !(sda_oe || host_low);
	always #20 clk_sys = ~clk_sys;
	thermal_alarm #(.TIMEOUT_CYC(200)) uut (.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe(sda_oe), .os_o(), .os_oe(os_oe), .conv_en(conv_en), .conv_done(conv_done),
		.conv_temp(conv_temp), .idle_period(idle_period));
	i2c_host_model h (.scl(scl), .sda_low(host_low), .sda(sda));
	task automatic tally_and_finish;
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic os(input logic e);
		chk("os_oe", {15'h0000, e}, {15'h0000, os_oe});
	endtask : os
	task automatic wreg(input logic [2:0] p, input logic [15:0] d, input int n);
		h.start();
		h.wb({DEV_ADDR_DEF, 1'b0}, ack);
		chk("addr_ack", 16'h0001, {15'h0000, ack});
		h.wb({5'h00, p}, ack);
		if (n > 0) h.wb(d[15:8], ack);
		if (n > 1) h.wb(d[7:0], ack);
		h.stop();
	endtask : wreg
	// pointer 7 here means keep the stored pointer
	task automatic rreg(input logic [2:0] p, input int n, output logic [15:0] d);
		d = 16'h0000;
		h.start();
		if (p != 3'h7) begin
			h.wb({DEV_ADDR_DEF, 1'b0}, ack);
			h.wb({5'h00, p}, ack);
			h.start();
		end
		h.wb({DEV_ADDR_DEF, 1'b1}, ack);
		h.rb(n > 1, d[15:8]);
		if (n > 1) h.rb(1'b0, d[7:0]);
		h.stop();
	endtask : rreg
	task automatic cfg(input logic [7:0] c);
		wreg(PTR_CONF, {c, 8'h00}, 1);
	endtask : cfg
	task automatic conv(input logic [10:0] t);
		@(negedge clk_sys);
		conv_done = 1'b1;
		conv_temp = t;
		@(negedge clk_sys);
		conv_done = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask : conv
	task automatic t_defaults;
		rreg(3'h7, 2, rd); chk("temp", 16'h0000, rd);
		rreg(PTR_CONF, 1, rd); chk("conf", 16'h0000, rd);
		rreg(PTR_OVER, 2, rd); chk("over", 16'h5000, rd);
		rreg(PTR_HYST, 2, rd); chk("hyst", 16'h4B00, rd);
		os(1'b0);
		h.start();
		h.wb({DEV_ADDR_DEF ^ 7'h01, 1'b0}, ack);
		h.stop();
		chk("foreign_ack", 16'h0000, {15'h0000, ack});
	endtask : t_defaults
	// limits kept at reset values, overtemp above hysteresis
	task automatic t_queue;
		for (int c = 0; c < 4; c++) begin
			cfg({3'h0, c[1:0], 3'h0});
			repeat (tbl[c] - 1) conv(HOT);
			conv(AT_OVER);
			repeat (tbl[c] - 1) conv(HOT);
			os(1'b0);
			conv(HOT); os(1'b1);
			rreg(PTR_TEMP, 2, rd); chk("temp", {HOT, 5'h00}, rd);
			os(1'b1);
			cfg({3'h0, c[1:0], 3'h1}); os(1'b1);
			chk("conv_en", 16'h0000, {15'h0000, conv_en});
			conv(COLD); os(1'b1);
			cfg({3'h0, c[1:0], 3'h0});
			repeat (tbl[c] - 1) conv(COLD);
			conv(AT_HYST);
			repeat (tbl[c] - 1) conv(COLD);
			os(1'b1);
			conv(COLD); os(1'b0);
		end
	endtask : t_queue
	task automatic t_pol;
		cfg(8'h04); os(1'b1);
		conv(HOT); os(1'b0);
		conv(COLD); os(1'b1);
		cfg(8'h00); os(1'b0);
	endtask : t_pol
	task automatic t_intr;
		cfg(8'h02);
		rreg(3'h7, 1, rd);
		os(1'b0);
		conv(HOT); conv(HOT); os(1'b1);
		rreg(PTR_CONF, 1, rd); chk("conf", 16'h0200, rd);
		os(1'b0);
		conv(COLD); os(1'b1);
		rreg(3'h7, 1, rd); os(1'b0);
		conv(HOT); os(1'b1);
		cfg(8'h03); os(1'b0);
		chk("conv_en", 16'h0000, {15'h0000, conv_en});
		cfg(8'h00);
		chk("conv_en", 16'h0001, {15'h0000, conv_en});
	endtask : t_intr
	task automatic t_regs;
		wreg(PTR_IDLE, {8'h1F, 8'h00}, 1);
		chk("idle", 16'h001F, {11'h000, idle_period});
		rreg(3'h5, 1, rd); chk("unmapped", 16'h0000, rd);
	endtask : t_regs
	task automatic t_tmo;
		logic       r;
		logic [7:0] a;
		a = {DEV_ADDR_DEF, 1'b0};
		h.start();
		for (int i = 7; i >= 0; i--)
			h.bitx(a[i], r);
		// host lets go of data, then freezes scl low in the ack slot
		h.sda_low = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("ack_hold", 16'h0001, {15'h0000, sda_oe});
		repeat (250) @(negedge clk_sys);
		chk("tmo_release", 16'h0000, {15'h0000, sda_oe});
		h.stop();
	endtask : t_tmo
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_defaults();
		t_queue();
		t_pol();
		t_intr();
		t_regs();
		t_tmo();
		tally_and_finish();
	end
endmodule : thermal_alarm_tb

/* src/thermal_alarm.sv */
// thermal alarm output logic: limits, fault queue, open-drain alarm, two-wire slave
// assumes conv_done and conv_temp come from logic on clk_sys; scl/sda from pins
// How it works
// - config bit 2 chooses alarm active level: one high, zero low.
// - polarity bit resets to zero, alarm starts active low.
// - config bit 1 chooses mode: one interrupt, zero comparator.
// - mode bit resets to zero, comparator mode after power-up.
// - comparator: assert above overtemp limit, release below hysteresis limit.
// - comparator: register reads and shutdown entry leave alarm untouched.
// - interrupt: alarm set by either crossing stays until any register read.
// - faults judged at conversion end; alarm after programmed consecutive trips.
// - fault count codes 0..3 mean 1, 2, 4, 6 consecutive trips.
// - fault count field resets to zero, one trip is enough.
// - config bit 0 set enters shutdown, cleared resumes periodic measurement.
// - shutdown stops conversions; serial reads and writes keep working.
// - shutdown entry keeps comparator alarm, clears interrupt alarm.
// - register pointer resets to the temperature register.
// - bus inactivity time-out enabled after reset.
// - each byte is eight data clocks plus one acknowledge clock.
// - device pulls data low in its acknowledge slot.
// - read ends with released data line for not-acknowledge, then stop.
// - a read may end after the first byte.
// - comparison uses the nine top bits of temperature data.
`timescale 1ns/10ps
module thermal_alarm #(
	parameter logic [6:0] DEV_ADDR    = thermal_alarm_pkg::DEV_ADDR_DEF,
	parameter int         TIMEOUT_CYC = thermal_alarm_pkg::TIMEOUT_CYC,
	parameter bit         TIMEOUT_EN  = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             os_o,
	output logic             os_oe,
	output logic             conv_en,
	input  wire logic        conv_done,
	input  wire logic [10:0] conv_temp,
	output logic [4:0]       idle_period
);
	import thermal_alarm_pkg::*;

	logic                 scl_m, scl_s, scl_d;
	logic                 sda_m, sda_s, sda_d;
	logic                 scl_rise, scl_fall, start_seen, stop_seen;
	bus_state_t           st;
	logic [3:0]           bit_idx;
	logic [7:0]           shreg, tx, wr_byte;
	logic                 addr_hit, rw_bit, ack_drive, host_ack, rd_lsb;
	logic [1:0]           byte_n;
	logic [2:0]           ptr, fcnt, fq_val;
	logic                 wr_stb, wr_lsb, reg_read, tmo, sd_enter;
	logic [19:0]          tmo_cnt;
	logic [CFG_WIDTH-1:0] conf;
	logic [8:0]           over_lim, hyst_lim, t9;
	logic [4:0]           idle_reg;
	logic [10:0]          temp_reg;
	logic                 side, pend, trip, alarm_act, next_sda_low;

	function automatic logic [7:0] rd_byte(input logic [2:0] p, input logic lsb);
		logic [7:0] b;
		b = 8'h00;
		unique case (p)
			PTR_TEMP: b = lsb ? {temp_reg[2:0], 5'h00} : temp_reg[10:3];
			PTR_CONF: b = {3'h0, conf};
			PTR_HYST: b = lsb ? {hyst_lim[0], 7'h00} : hyst_lim[8:1];
			PTR_OVER: b = lsb ? {over_lim[0], 7'h00} : over_lim[8:1];
			PTR_IDLE: b = {3'h0, idle_reg};
			default:  b = 8'h00;
		endcase
		return b;
	endfunction : rd_byte

	// pins cross into clk_sys; third stage only for edge finding
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end
	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tmo_cnt <= 20'h0_0000;
			tmo     <= 1'b0;
		end else if (TIMEOUT_EN && st != ST_IDLE && !scl_s) begin
			tmo     <= (tmo_cnt == 20'(TIMEOUT_CYC - 1));
			tmo_cnt <= (tmo_cnt == 20'(TIMEOUT_CYC - 1)) ? 20'h0_0000 : tmo_cnt + 20'h0_0001;
		end else begin
			tmo_cnt <= 20'h0_0000;
			tmo     <= 1'b0;
		end
	end

	// byte engine; every transfer is 8 data slots then one ack slot
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st        <= ST_IDLE;
			bit_idx   <= IDX_PRE;
			shreg     <= 8'h00;
			tx        <= 8'hFF;
			addr_hit  <= 1'b0;
			rw_bit    <= 1'b0;
			ack_drive <= 1'b0;
			host_ack  <= 1'b0;
			byte_n    <= 2'h0;
			rd_lsb    <= 1'b0;
			ptr       <= PTR_TEMP;
			wr_stb    <= 1'b0;
			wr_lsb    <= 1'b0;
			wr_byte   <= 8'h00;
			reg_read  <= 1'b0;
		end else begin
			wr_stb   <= 1'b0;
			reg_read <= 1'b0;
			if (start_seen) begin
				st        <= ST_ADDR;
				bit_idx   <= IDX_PRE;
				ack_drive <= 1'b0;
			end else if (stop_seen || tmo) begin
				st        <= ST_IDLE;
				ack_drive <= 1'b0;
			end else if (st != ST_IDLE && scl_rise) begin
				// eight data clocks then ack clock
				if (bit_idx <= IDX_LAST)
					shreg <= {shreg[6:0], sda_s};
				else if (bit_idx == IDX_ACK)
					host_ack <= ~sda_s;
			end else if (st != ST_IDLE && scl_fall) begin
				if (bit_idx == IDX_PRE) begin
					bit_idx <= 4'h0;
				end else if (bit_idx == IDX_LAST) begin
					bit_idx <= IDX_ACK;
					unique case (st)
						ST_ADDR: begin
							addr_hit  <= (shreg[7:1] == DEV_ADDR);
							rw_bit    <= shreg[0];
							ack_drive <= (shreg[7:1] == DEV_ADDR);
						end
						ST_WRITE: begin
							ack_drive <= 1'b1;
							if (byte_n == 2'h0) begin
								ptr <= shreg[2:0];
							end else if (byte_n != 2'h3) begin
								wr_stb  <= 1'b1;
								wr_lsb  <= (byte_n == 2'h2);
								wr_byte <= shreg;
							end
							if (byte_n != 2'h3)
								byte_n <= byte_n + 2'h1;
						end
						// released in the master ack slot
						ST_READ: ack_drive <= 1'b0;
						default: ack_drive <= 1'b0;
					endcase
				end else if (bit_idx == IDX_ACK) begin
					bit_idx   <= 4'h0;
					ack_drive <= 1'b0;
					if (st == ST_ADDR) begin
						if (!addr_hit) begin
							st <= ST_IDLE;
						end else if (rw_bit) begin
							st       <= ST_READ;
							tx       <= rd_byte(ptr, 1'b0);
							rd_lsb   <= 1'b1;
							reg_read <= 1'b1;
						end else begin
							st     <= ST_WRITE;
							byte_n <= 2'h0;
						end
					end else if (st == ST_READ) begin
						// host ack asks for the next byte
						if (host_ack) begin
							tx     <= rd_byte(ptr, rd_lsb);
							rd_lsb <= ~rd_lsb;
						end else begin
							// read may stop after any byte
							st <= ST_IDLE;
						end
					end
				end else begin
					bit_idx <= bit_idx + 4'h1;
					if (st == ST_READ)
						tx <= {tx[6:0], 1'b1};
				end
			end
		end
	end
	always_comb begin
		next_sda_low = 1'b0;
		if (bit_idx == IDX_ACK && ack_drive)
			next_sda_low = 1'b1;
		else if (st == ST_READ && bit_idx <= IDX_LAST)
			next_sda_low = ~tx[7];
	end
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			sda_oe <= next_sda_low;
			sda_o  <= 1'b0;
		end
	end
	// register writes
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			conf     <= CONF_RST;
			over_lim <= OVER_RST;
			hyst_lim <= HYST_RST;
			idle_reg <= IDLE_RST;
			sd_enter <= 1'b0;
		end else begin
			sd_enter <= 1'b0;
			if (wr_stb) begin
				unique case (ptr)
					PTR_CONF: begin
						if (!wr_lsb) begin
							conf     <= wr_byte[CFG_WIDTH-1:0];
							sd_enter <= wr_byte[CFG_SHUTDOWN] & ~conf[CFG_SHUTDOWN];
						end
					end
					PTR_OVER: begin
						if (wr_lsb)
							over_lim[0] <= wr_byte[7];
						else
							over_lim[8:1] <= wr_byte;
					end
					PTR_HYST: begin
						if (wr_lsb)
							hyst_lim[0] <= wr_byte[7];
						else
							hyst_lim[8:1] <= wr_byte;
					end
					PTR_IDLE: begin
						if (!wr_lsb)
							idle_reg <= wr_byte[4:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	assign conv_en     = ~conf[CFG_SHUTDOWN];
	assign idle_period = idle_reg;
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			temp_reg <= TEMP_RST;
		else if (conv_done && conv_en)
			temp_reg <= conv_temp;
	end
	always_comb begin
		unique case (conf[CFG_FQ_HI:CFG_FQ_LO])
			2'h0: fq_val = FQ_VAL0;
			2'h1: fq_val = FQ_VAL1;
			2'h2: fq_val = FQ_VAL2;
			2'h3: fq_val = FQ_VAL3;
		endcase
	end
	assign t9 = conv_temp[10:2];
	// above limit when inactive, below hysteresis when active
	assign trip = side ? ($signed(t9) < $signed(hyst_lim)) : ($signed(t9) > $signed(over_lim));
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			side <= 1'b0;
			fcnt <= 3'h0;
		end else if (conv_done && conv_en) begin
			if (trip) begin
				if (fcnt + 3'h1 >= fq_val) begin
					side <= ~side;
					fcnt <= 3'h0;
				end else begin
					fcnt <= fcnt + 3'h1;
				end
			end else begin
				fcnt <= 3'h0;
			end
		end
	end

	// pending cleared by read or shutdown; new event wins
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			pend <= 1'b0;
		else if (conv_done && conv_en && trip && (fcnt + 3'h1 >= fq_val))
			pend <= 1'b1;
		else if (reg_read || sd_enter)
			pend <= 1'b0;
	end
	assign alarm_act = conf[CFG_MODE] ? pend : side;
	// polarity: pin pulled low when at its active-low or idle-low level
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			os_oe <= 1'b0;
			os_o  <= 1'b0;
		end else begin
			os_oe <= conf[CFG_POL] ? ~alarm_act : alarm_act;
			os_o  <= 1'b0;
		end
	end

endmodule : thermal_alarm

/* src/thermal_alarm_pkg.sv */
// constants for the thermal alarm output logic and its two-wire register port
// assumes a 25 MHz system clock and a conversion engine outside the block
package thermal_alarm_pkg;
	// system clock
	localparam int CLK_KHZ = 25_000;
	// bus inactivity time-out, minimum hold of scl low
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	// arbitrary default bus address
	localparam logic [6:0] DEV_ADDR_DEF = 7'h48;
	// register pointer values
	localparam logic [2:0] PTR_TEMP = 3'h0;
	localparam logic [2:0] PTR_CONF = 3'h1;
	localparam logic [2:0] PTR_HYST = 3'h2;
	localparam logic [2:0] PTR_OVER = 3'h3;
	localparam logic [2:0] PTR_IDLE = 3'h4;
	// alarm_config field positions
	localparam int CFG_SHUTDOWN = 0;
	localparam int CFG_MODE = 1;
	localparam int CFG_POL = 2;
	localparam int CFG_FQ_LO = 3;
	localparam int CFG_FQ_HI = 4;
	localparam int CFG_WIDTH = 5;
	// reset values
	localparam logic [4:0] CONF_RST = 5'h00;
	localparam logic [8:0] OVER_RST = 9'h0A0;
	localparam logic [8:0] HYST_RST = 9'h096;
	localparam logic [4:0] IDLE_RST = 5'h01;
	localparam logic [10:0] TEMP_RST = 11'h000;
	// fault queue values per code
	localparam logic [2:0] FQ_VAL0 = 3'h1;
	localparam logic [2:0] FQ_VAL1 = 3'h2;
	localparam logic [2:0] FQ_VAL2 = 3'h4;
	localparam logic [2:0] FQ_VAL3 = 3'h6;
	// bit slot index: 0..7 data, 8 acknowledge, 15 waiting for first clock
	localparam logic [3:0] IDX_ACK = 4'h8;
	localparam logic [3:0] IDX_LAST = 4'h7;
	localparam logic [3:0] IDX_PRE = 4'hF;
	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} bus_state_t;
endpackage : thermal_alarm_pkg
